// file: inc/adc_ctrl_pkg.sv
package adc_ctrl_pkg;
  // byte offsets on the register bus
  localparam logic [4:0] OFS_INPUT_SELECT   = 5'h00;
  localparam logic [4:0] OFS_CONTROL_A      = 5'h04;
  localparam logic [4:0] OFS_RESULT_LOW     = 5'h08;
  localparam logic [4:0] OFS_RESULT_HIGH    = 5'h0c;
  localparam logic [4:0] OFS_TRIGGER_SELECT = 5'h10;
  localparam logic [4:0] OFS_PIN_DISABLE    = 5'h14;
  // input select fields
  localparam int REF_SEL_BIT     = 6;
  localparam int LEFT_ADJ_BIT    = 5;
  localparam int CHAN_LSB        = 0;
  // control a fields
  localparam int ENABLE_BIT      = 7;
  localparam int START_BIT       = 6;
  localparam int AUTO_TRIG_BIT   = 5;
  localparam int DONE_FLAG_BIT   = 4;
  localparam int DONE_IE_BIT     = 3;
  localparam int DIV_LSB         = 0;
  // trigger select and pin disable fields
  localparam int TRIG_SRC_LSB    = 0;
  localparam int PIN_OFF_LSB     = 2;
  // reset values
  localparam logic [7:0] INPUT_SELECT_RESET   = 8'h00;
  localparam logic [7:0] CONTROL_A_RESET      = 8'h00;
  localparam logic [7:0] TRIGGER_SELECT_RESET = 8'h00;
  localparam logic [7:0] PIN_DISABLE_RESET    = 8'h00;
  localparam logic [9:0] RESULT_RESET         = 10'h000;
  // converter clock cycles per conversion, then the free running trigger code
  localparam logic [4:0] FIRST_CONV_CYCLES  = 5'h19;
  localparam logic [4:0] NORMAL_CONV_CYCLES = 5'h0d;
  localparam logic [2:0] TRIG_FREE_RUN      = 3'h0;
endpackage : adc_ctrl_pkg

// file: hdl/adc_control_registers.sv
// What this block does
// R1: reference select picks supply or internal reference
// R2: reference change waits for running conversion end
// R3: channel code 0..3 connects input 0..3
// R4: channel change waits for running conversion end
// R5: left adjust changes result view immediately
// R6: reserved bits always read as zero
// R7: enable powers core; clearing aborts conversion
// R8: start bit starts single or first conversion
// R9: first conversion 25 cycles, later 13
// R10: start reads one while busy; zero ignored
// R11: auto trigger starts on selected source edge
// R12: flag set at end; irq when enabled
// R13: flag cleared by vector or writing one
// R14: software avoids read-modify-write on control register
// R15: prescaler divides clock by 2 up to 128
// R16: low byte read locks result until high read
// R17: right or left aligned result byte layout
// R18: trigger source field selects seven trigger sources
// R19: source field ignored without auto trigger
// R20: source switch to set is edge; free run never
// R21: disable bits kill digital input, read zero
// R22: free running restarts at each completion
// R23: flag, result, start clear in same cycle; free running keeps start set
`timescale 1ns/10ps
module adc_control_registers #(
  parameter int ADDR_W = 5
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic [ADDR_W-1:0] adr_i,
  input  wire logic [31:0]       dat_i,
  output logic      [31:0]       dat_o,
  input  wire logic              we_i,
  input  wire logic [3:0]        sel_i,
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  output logic                   ack_o,
  output logic                   core_power_o,
  output logic                   core_start_o,
  output logic                   core_clk_tick_o,
  output logic      [1:0]        core_channel_o,
  output logic                   core_reference_o,
  input  wire logic [9:0]        conv_value_i,
  input  wire logic [5:0]        trig_flags_i,
  input  wire logic              global_irq_enable_i,
  input  wire logic              irq_vector_ack_i,
  output logic                   irq_o,
  input  wire logic [3:0]        pin_raw_i,
  output logic      [3:0]        pin_value_o,
  output logic      [3:0]        pin_buffer_off_o
);

  logic       ack_q;
  logic       acc_wr;
  logic       acc_rd;
  logic       ref_sel_q;
  logic       left_adj_q;
  logic [1:0] chan_q;
  logic       en_q;
  logic       ate_q;
  logic       flag_q;
  logic       ie_q;
  logic [2:0] div_q;
  logic [2:0] src_q;
  logic [3:0] pin_off_q;
  logic       busy_q;
  logic       first_q;
  logic [4:0] conv_cnt_q;
  logic [6:0] div_cnt_q;
  logic [6:0] div_last;
  logic       tick;
  logic [4:0] conv_len;
  logic       done;
  logic [9:0] result_q;
  logic       lock_q;
  logic       act_ref_q;
  logic [1:0] act_chan_q;
  logic       trig_sel;
  logic       trig_prev_q;
  logic       trig_edge;
  logic       wr_sel;
  logic       wr_ctrl;
  logic       wr_trig;
  logic       wr_pin;
  logic       turn_off;
  logic       sw_start;
  logic       trig_start;
  logic       start;
  logic       restart;
  logic [7:0] rdata;
  logic [3:0] pin_meta_q;
  logic [3:0] pin_sync_q;

  // write and read side effects land on the edge where the master sees ack
  assign acc_wr  = cyc_i & stb_i & ack_q & we_i & sel_i[0];
  assign acc_rd  = cyc_i & stb_i & ack_q & ~we_i;
  assign wr_sel  = acc_wr & (adr_i == adc_ctrl_pkg::OFS_INPUT_SELECT);
  assign wr_ctrl = acc_wr & (adr_i == adc_ctrl_pkg::OFS_CONTROL_A);
  assign wr_trig = acc_wr & (adr_i == adc_ctrl_pkg::OFS_TRIGGER_SELECT);
  assign wr_pin  = acc_wr & (adr_i == adc_ctrl_pkg::OFS_PIN_DISABLE);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_q <= 1'b0;
    else
      ack_q <= cyc_i & stb_i & ~ack_q;
  end
  assign ack_o = ack_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ref_sel_q  <= adc_ctrl_pkg::INPUT_SELECT_RESET[adc_ctrl_pkg::REF_SEL_BIT];
      left_adj_q <= adc_ctrl_pkg::INPUT_SELECT_RESET[adc_ctrl_pkg::LEFT_ADJ_BIT];
      chan_q     <= adc_ctrl_pkg::INPUT_SELECT_RESET[adc_ctrl_pkg::CHAN_LSB +: 2];
    end
    else if (wr_sel)
    begin
      ref_sel_q  <= dat_i[adc_ctrl_pkg::REF_SEL_BIT];
      left_adj_q <= dat_i[adc_ctrl_pkg::LEFT_ADJ_BIT];
      chan_q     <= dat_i[adc_ctrl_pkg::CHAN_LSB +: 2];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      en_q  <= adc_ctrl_pkg::CONTROL_A_RESET[adc_ctrl_pkg::ENABLE_BIT];
      ate_q <= adc_ctrl_pkg::CONTROL_A_RESET[adc_ctrl_pkg::AUTO_TRIG_BIT];
      ie_q  <= adc_ctrl_pkg::CONTROL_A_RESET[adc_ctrl_pkg::DONE_IE_BIT];
      div_q <= adc_ctrl_pkg::CONTROL_A_RESET[adc_ctrl_pkg::DIV_LSB +: 3];
    end
    else if (wr_ctrl)
    begin
      en_q  <= dat_i[adc_ctrl_pkg::ENABLE_BIT];
      ate_q <= dat_i[adc_ctrl_pkg::AUTO_TRIG_BIT];
      ie_q  <= dat_i[adc_ctrl_pkg::DONE_IE_BIT];
      div_q <= dat_i[adc_ctrl_pkg::DIV_LSB +: 3];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      src_q     <= adc_ctrl_pkg::TRIGGER_SELECT_RESET[adc_ctrl_pkg::TRIG_SRC_LSB +: 3];
      pin_off_q <= adc_ctrl_pkg::PIN_DISABLE_RESET[adc_ctrl_pkg::PIN_OFF_LSB +: 4];
    end
    else
    begin
      if (wr_trig)
        src_q <= dat_i[adc_ctrl_pkg::TRIG_SRC_LSB +: 3];
      if (wr_pin)
        pin_off_q <= dat_i[adc_ctrl_pkg::PIN_OFF_LSB +: 4];
    end
  end

  // R15: prescaler divide factor
  always_comb
  begin
    if (div_q <= 3'h1)
      div_last = 7'h01;
    else
      div_last = 7'((8'h01 << div_q) - 8'h01);
  end
  assign tick = en_q & (div_cnt_q == div_last);

  // counter restarts with each conversion so every one starts on a full period
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !en_q || start || tick)
      div_cnt_q <= 7'h00;
    else
      div_cnt_q <= div_cnt_q + 7'h01;
  end

  // R18: trigger source decode, code 7 selects nothing
  always_comb
  begin
    if (src_q == adc_ctrl_pkg::TRIG_FREE_RUN || src_q == 3'h7)
      trig_sel = 1'b0;
    else
      trig_sel = trig_flags_i[src_q - 3'h1];
  end

  // R20: previous level follows the selected source, so a switch is an edge
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      trig_prev_q <= 1'b0;
    else
      trig_prev_q <= trig_sel;
  end
  assign trig_edge = trig_sel & ~trig_prev_q;

  assign turn_off = wr_ctrl & ~dat_i[adc_ctrl_pkg::ENABLE_BIT];
  // R8: start bit written with enable set
  assign sw_start = wr_ctrl & dat_i[adc_ctrl_pkg::START_BIT] & dat_i[adc_ctrl_pkg::ENABLE_BIT];
  // R11: auto trigger edge; R19: gated by auto trigger enable
  assign trig_start = ate_q & en_q & trig_edge;
  assign start = (sw_start | trig_start) & ~busy_q & ~turn_off;
  // R9: first conversion after enable takes the long count
  assign conv_len = first_q ? adc_ctrl_pkg::FIRST_CONV_CYCLES
                            : adc_ctrl_pkg::NORMAL_CONV_CYCLES;
  assign done = busy_q & tick & (conv_cnt_q == conv_len - 5'h01);
  // R22: free running mode chains the next conversion
  assign restart = done & ate_q & (src_q == adc_ctrl_pkg::TRIG_FREE_RUN) & ~turn_off;

  // R7: disabling aborts; R23: busy drops in the done cycle unless free running restarts
  always_ff @(posedge clk_i)
  begin
    if (rst_i || turn_off)
      busy_q <= 1'b0;
    else if (start)
      busy_q <= 1'b1;
    else if (done)
      busy_q <= restart;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || !en_q)
      first_q <= 1'b1;
    else if (done)
      first_q <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || start || done)
      conv_cnt_q <= 5'h00;
    else if (busy_q && tick)
      conv_cnt_q <= conv_cnt_q + 5'h01;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      core_start_o <= 1'b0;
    else
      core_start_o <= start | restart;
  end

  // R2: reference held while converting; R4: channel held likewise
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      act_ref_q  <= adc_ctrl_pkg::INPUT_SELECT_RESET[adc_ctrl_pkg::REF_SEL_BIT];
      act_chan_q <= adc_ctrl_pkg::INPUT_SELECT_RESET[adc_ctrl_pkg::CHAN_LSB +: 2];
    end
    else if (!busy_q || done)
    begin
      act_ref_q  <= ref_sel_q;
      act_chan_q <= chan_q;
    end
  end

  // R13: set wins over a clear in the same cycle; R12: set at completion
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      flag_q <= adc_ctrl_pkg::CONTROL_A_RESET[adc_ctrl_pkg::DONE_FLAG_BIT];
    else if (done)
      flag_q <= 1'b1;
    else if (irq_vector_ack_i || (wr_ctrl && dat_i[adc_ctrl_pkg::DONE_FLAG_BIT]))
      flag_q <= 1'b0;
  end

  // R16: result frozen between low byte read and high byte read
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      lock_q <= 1'b0;
    else if (acc_rd && adr_i == adc_ctrl_pkg::OFS_RESULT_HIGH)
      lock_q <= 1'b0;
    else if (acc_rd && adr_i == adc_ctrl_pkg::OFS_RESULT_LOW)
      lock_q <= 1'b1;
  end

  // R23: result loads on the same edge as flag set; a locked result is lost
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      result_q <= adc_ctrl_pkg::RESULT_RESET;
    else if (done && !lock_q)
      result_q <= conv_value_i;
  end

  // R21: pins synchronised, then masked by their disable bits
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_meta_q <= 4'h0;
      pin_sync_q <= 4'h0;
    end
    else
    begin
      pin_meta_q <= pin_raw_i;
      pin_sync_q <= pin_meta_q;
    end
  end
  assign pin_value_o      = pin_sync_q & ~pin_off_q;
  assign pin_buffer_off_o = pin_off_q;

  // R7: core power follows enable
  assign core_power_o     = en_q;
  assign core_clk_tick_o  = tick;
  // R1: reference select; R3: channel to converter
  assign core_reference_o = act_ref_q;
  assign core_channel_o   = act_chan_q;
  // R12: interrupt request needs flag, local and global enable
  assign irq_o = flag_q & ie_q & global_irq_enable_i;

  // R6: reserved bits read zero; R10: start reads busy; R5, R17: alignment
  always_comb
  begin
    if (adr_i == adc_ctrl_pkg::OFS_INPUT_SELECT)
      rdata = {1'b0, ref_sel_q, left_adj_q, 3'h0, chan_q};
    else if (adr_i == adc_ctrl_pkg::OFS_CONTROL_A)
      rdata = {en_q, busy_q, ate_q, flag_q, ie_q, div_q};
    else if (adr_i == adc_ctrl_pkg::OFS_RESULT_LOW)
      rdata = left_adj_q ? {result_q[1:0], 6'h00} : result_q[7:0];
    else if (adr_i == adc_ctrl_pkg::OFS_RESULT_HIGH)
      rdata = left_adj_q ? result_q[9:2] : {6'h00, result_q[9:8]};
    else if (adr_i == adc_ctrl_pkg::OFS_TRIGGER_SELECT)
      rdata = {5'h00, src_q};
    else if (adr_i == adc_ctrl_pkg::OFS_PIN_DISABLE)
      rdata = {2'h0, pin_off_q, 2'h0};
    else
      rdata = 8'h00;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_o <= 32'h0000_0000;
    else if (cyc_i && stb_i && !ack_q)
      dat_o <= {24'h00_0000, rdata};
  end

  flag_set_a: assert property (@(posedge clk_i) disable iff (rst_i)  // R12
    done |=> flag_q && (busy_q == $past(restart)))
    else $error("flag not set after conversion end");

  start_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)  // R23
    done && !restart |=> !busy_q ##0 $past(busy_q))
    else $error("busy not cleared at conversion end");

  abort_off_a: assert property (@(posedge clk_i) disable iff (rst_i)  // R7
    turn_off |=> !busy_q && !core_power_o)
    else $error("disable did not abort conversion");

  lock_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)  // R16
    lock_q && done |=> $stable(result_q))
    else $error("locked result changed");

  chan_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)  // R4
    busy_q && !done |=> $stable(core_channel_o) && $stable(core_reference_o))
    else $error("channel changed during conversion");

  trig_start_a: assert property (@(posedge clk_i) disable iff (rst_i)  // R11
    ate_q && en_q && trig_edge && !busy_q && !turn_off |=> busy_q ##0 core_start_o)
    else $error("trigger edge did not start conversion");

  rsvd_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)  // R6
    ack_q && $past(adr_i) == adc_ctrl_pkg::OFS_INPUT_SELECT |-> dat_o[7] == 1'b0
      && dat_o[4:2] == 3'h0)
    else $error("reserved bits read nonzero");

  left_low_a: assert property (@(posedge clk_i) disable iff (rst_i)  // R17
    ack_q && left_adj_q && $past(left_adj_q)
      && $past(adr_i) == adc_ctrl_pkg::OFS_RESULT_LOW |-> dat_o[5:0] == 6'h00)
    else $error("left adjusted low byte has stray bits");

  first_len_a: assert property (@(posedge clk_i) disable iff (rst_i)  // R9
    done |-> conv_cnt_q == (first_q ? adc_ctrl_pkg::FIRST_CONV_CYCLES - 5'h01
                                    : adc_ctrl_pkg::NORMAL_CONV_CYCLES - 5'h01))
    else $error("conversion length wrong");

endmodule : adc_control_registers

// file: sim/conv_core_model.sv
`timescale 1ns/10ps
module conv_core_model (
  input  wire logic       clk_i,
  input  wire logic       power_i,
  input  wire logic       start_i,
  input  wire logic [1:0] channel_i,
  input  wire logic       reference_i,
  output logic      [9:0] value_o
);
  logic [2:0] pick_q = 3'h0;
  always @(posedge clk_i)
  begin
    if (start_i === 1'b1)
      pick_q <= {reference_i, channel_i};
  end
  // the value names its own channel and reference so a stale pick shows up
  // an unpowered core gives nothing valid, so show the inverse
  assign value_o = (power_i === 1'b1) ? {pick_q, 7'h2b} : ~{pick_q, 7'h2b};
endmodule : conv_core_model

// file: sim/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  typedef struct packed {
    logic [4:0] a;
    logic [7:0] w;
    logic [7:0] r;
    logic [3:0] p;
  } row_t;
  localparam logic [9:0] VAL_CH2 = 10'h32b;
  localparam logic [9:0] VAL_CH1 = 10'h0ab;
  row_t rows [6] = '{'{5'h00, 8'hff, 8'h63, 4'hf}, '{5'h10, 8'hff, 8'h07, 4'hf},
                     '{5'h14, 8'h0c, 8'h0c, 4'hc}, '{5'h14, 8'hff, 8'h3c, 4'h0},
                     '{5'h04, 8'h07, 8'h07, 4'h0}, '{5'h18, 8'hff, 8'h00, 4'h0}};
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [4:0]  adr_i = 5'h00;
  logic [31:0] dat_i = 32'h0;
  logic        we_i = 1'b0;
  logic [3:0]  sel_i = 4'h0;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic [5:0]  trig_flags_i = 6'h00;
  logic        global_irq_enable_i = 1'b1;
  logic        irq_vector_ack_i = 1'b0;
  logic [3:0]  pin_raw_i = 4'hf;
  logic [31:0] dat_o;
  logic        ack_o, core_power_o, core_start_o, core_clk_tick_o, core_reference_o, irq_o;
  logic [1:0]  core_channel_o;
  logic [9:0]  conv_value_i;
  logic [3:0]  pin_value_o, pin_buffer_off_o;
  logic [7:0]  gcnt = 8'h00;
  logic [7:0]  gap = 8'h00;
  logic [5:0]  tcnt = 6'h00;
  logic [5:0]  cap = 6'h00;
  logic        irq_d = 1'b0;
  int          mismatches = 0;
  int          tests_run = 0;

  adc_control_registers DUT (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
    .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
    .core_power_o(core_power_o), .core_start_o(core_start_o),
    .core_clk_tick_o(core_clk_tick_o), .core_channel_o(core_channel_o),
    .core_reference_o(core_reference_o), .conv_value_i(conv_value_i),
    .trig_flags_i(trig_flags_i), .global_irq_enable_i(global_irq_enable_i),
    .irq_vector_ack_i(irq_vector_ack_i), .irq_o(irq_o), .pin_raw_i(pin_raw_i),
    .pin_value_o(pin_value_o), .pin_buffer_off_o(pin_buffer_off_o));
  conv_core_model core (.clk_i(clk_i), .power_i(core_power_o), .start_i(core_start_o),
    .channel_i(core_channel_o), .reference_i(core_reference_o), .value_o(conv_value_i));

  initial
  begin
    forever #5 clk_i = ~clk_i;
  end

  // tick spacing updated at each tick, ticks per conversion captured when irq rises
  always @(posedge clk_i)
  begin
    irq_d <= irq_o;
    gcnt <= (core_clk_tick_o === 1'b1) ? 8'h01 : gcnt + 8'h01;
    if (core_clk_tick_o === 1'b1)
      gap <= gcnt;
    if (core_start_o === 1'b1)
      tcnt <= {5'h00, core_clk_tick_o};
    else if (core_clk_tick_o === 1'b1)
      tcnt <= tcnt + 6'h01;
    if (irq_o === 1'b1 && irq_d === 1'b0)
      cap <= tcnt;
  end

  task automatic wrap_up();
    if (mismatches == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [4:0] a, input logic [7:0] d,
                    output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {24'h000000, d};
    sel_i <= 4'h1;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    q = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    if (n >= 20)
    begin
      mismatches++;
      $display("unexpected at %0t: no bus acknowledge", $time);
    end
  endtask : wb

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, a, d, q);
  endtask : wr

  task automatic rdc(input logic [4:0] a, input logic [7:0] e);
    logic [7:0] q;
    wb(1'b0, a, 8'h00, q);
    chk(32'(q), 32'(e));
  endtask : rdc

  task automatic wait_irq();
    int n;
    n = 0;
    @(posedge clk_i);
    while (irq_o !== 1'b1 && n < 2000)
    begin
      @(posedge clk_i);
      n++;
    end
    @(posedge clk_i);
    chk(32'(n < 2000), 32'h1);
  endtask : wait_irq

  function automatic logic [7:0] rbyte(input logic [9:0] v, input logic l, input logic h);
    logic [15:0] w;
    w = l ? {v, 6'h00} : {6'h00, v};
    return h ? w[15:8] : w[7:0];
  endfunction : rbyte

  initial
  begin
    #200us;
    mismatches++;
    wrap_up();
  end

  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int a = 0; a < 6; a++)
      rdc(5'(a * 4), 8'h00);
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].w);
      rdc(rows[i].a, rows[i].r);
      chk(32'(pin_value_o), 32'(rows[i].p));
      chk(32'(pin_buffer_off_o), 32'(4'(~rows[i].p)));
    end
    wr(5'h14, 8'h00);
    wr(5'h10, 8'h00);
    wr(5'h00, 8'h42);
    wr(5'h04, 8'hc8);
    wait_irq();
    chk(32'(cap), 32'h19);
    chk(32'(gap), 32'h2);
    rdc(5'h04, 8'h98);
    rdc(5'h08, rbyte(VAL_CH2, 1'b0, 1'b0));
    rdc(5'h0c, rbyte(VAL_CH2, 1'b0, 1'b1));
    wr(5'h00, 8'h62);
    rdc(5'h08, rbyte(VAL_CH2, 1'b1, 1'b0));
    rdc(5'h0c, rbyte(VAL_CH2, 1'b1, 1'b1));
    global_irq_enable_i <= 1'b0;
    @(posedge clk_i);
    chk(32'(irq_o), 32'h0);
    global_irq_enable_i <= 1'b1;
    irq_vector_ack_i <= 1'b1;
    @(posedge clk_i);
    irq_vector_ack_i <= 1'b0;
    rdc(5'h04, 8'h88);
    wr(5'h00, 8'h42);
    wr(5'h04, 8'hc8);
    wr(5'h00, 8'h01);
    rdc(5'h04, 8'hc8);
    chk(32'({core_reference_o, core_channel_o}), 32'h6);
    wait_irq();
    chk(32'(cap), 32'h0d);
    rdc(5'h08, rbyte(VAL_CH2, 1'b0, 1'b0));
    wr(5'h04, 8'h98);
    rdc(5'h04, 8'h88);
    wr(5'h04, 8'hc8);
    wait_irq();
    rdc(5'h0c, rbyte(VAL_CH2, 1'b0, 1'b1));
    wr(5'h04, 8'hd8);
    wait_irq();
    rdc(5'h08, rbyte(VAL_CH1, 1'b0, 1'b0));
    for (int k = 1; k < 7; k++)
    begin
      wr(5'h04, 8'h98);
      wr(5'h10, 8'(k));
      wr(5'h04, 8'ha8 | 8'(k));
      trig_flags_i <= 6'h01 << (k - 1);
      wait_irq();
      chk(32'(gap), 32'h1 << k);
      trig_flags_i <= 6'h00;
    end
    wr(5'h04, 8'h98);
    trig_flags_i <= 6'h20;
    repeat (4) @(posedge clk_i);
    rdc(5'h04, 8'h88);
    wr(5'h10, 8'h01);
    wr(5'h04, 8'ha8);
    rdc(5'h04, 8'ha8);
    wr(5'h10, 8'h06);
    wait_irq();
    trig_flags_i <= 6'h00;
    wr(5'h10, 8'h00);
    rdc(5'h04, 8'hb8);
    wr(5'h04, 8'hf8);
    wait_irq();
    wr(5'h04, 8'hb8);
    wait_irq();
    chk(32'(cap), 32'h0d);
    wr(5'h04, 8'h10);
    @(posedge clk_i);
    chk(32'(core_power_o), 32'h0);
    repeat (100) @(posedge clk_i);
    rdc(5'h04, 8'h00);
    wr(5'h04, 8'hc8);
    wait_irq();
    chk(32'(cap), 32'h19);
    // mid-run reset with a pending flag and the converter enabled
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    chk(32'(irq_o), 32'h0);
    for (int a = 0; a < 6; a++)
      rdc(5'(a * 4), 8'h00);
    wrap_up();
  end
endmodule : tb_top
